//--- tah_map.vh
// Register map, field positions and timing constants of the timer/alarm/hush block.
// Assumes inclusion by bare name from the design files.
`ifndef TAH_MAP_VH
`define TAH_MAP_VH
// ----------------------------------------------------------------
// Register word offsets
// ----------------------------------------------------------------
`define TAH_OFF_NS        4'h0
`define TAH_OFF_SEC       4'h1
`define TAH_OFF_ALARM     4'h2
`define TAH_OFF_HOLD      4'h3
`define TAH_OFF_SRC       4'h4
`define TAH_OFF_MASK_EXT  4'h5
`define TAH_OFF_MASK_INT  4'h6
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TAH_HOLD_BIT      0
`define TAH_HOLD_ERR_BIT  1
`define TAH_SRC_PROC_LO   1
`define TAH_SRC_PROC_HI   6
`define TAH_SRC_ALARM     7
`define TAH_SRC_HOLD_ERR  8
`define TAH_SRC_EXT_LO    9
`define TAH_SRC_EXT_HI    15
`define TAH_SRC_OTH_HALT  16
`define TAH_SRC_INP_HALT  17
// ----------------------------------------------------------------
// Values and timing
// ----------------------------------------------------------------
`define TAH_TICK_NS       32'h0000_00c8
`define TAH_NS_WRAP       32'h3b9a_ca00
`define TAH_ZERO32        32'h0000_0000
`define TAH_HOLD_TICKS    12'h09c4
`define TAH_SYS_MHZ       25
`define TAH_REF_MHZ       5
// Exception codes
`define TAH_EXC_NONE      6'h00
`define TAH_EXC_DATA_ACC  6'h04
`define TAH_EXC_OUT_PROC  6'h08
`define TAH_EXC_OUT_ROUTE 6'h09
`define TAH_EXC_OUT_TMO   6'h0b
`define TAH_EXC_EVQ_OVF   6'h0c
`define TAH_EXC_Q_OVF     6'h0d
`define TAH_EXC_UNIMPL    6'h10
`define TAH_EXC_PKT_SEQ   6'h11
`define TAH_EXC_EVT_INT   6'h12
`define TAH_EXC_DMA_FAIL  6'h14
`endif

//--- tah_sync.v
// Three-stage synchroniser bank with agreement filter.
// Assumes asynchronous inputs and the system clock.
`timescale 1ns/100ps
`default_nettype none
module tah_sync #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire             i_sys_clk,
  input  wire             i_nrst,
  // Data
  input  wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] s1_r;
  reg [WIDTH-1:0] s2_r;
  reg [WIDTH-1:0] s3_r;
  reg [WIDTH-1:0] out_r;
  genvar g;
  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  always @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      s1_r <= {WIDTH{1'b0}};
      s2_r <= {WIDTH{1'b0}};
      s3_r <= {WIDTH{1'b0}};
    end
    else
    begin
      s1_r <= i_async;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  // Change accepted only when stages two and three agree
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : g_bit
      always @(posedge i_sys_clk or negedge i_nrst)
      begin
        if (!i_nrst)
          out_r[g] <= 1'b0;
        else if (s2_r[g] == s3_r[g])
          out_r[g] <= s3_r[g];
      end
    end
  endgenerate
  assign o_sync = out_r;
endmodule // tah_sync
`default_nettype wire

//--- tah_top.v
// Timer, alarm, bus hold and interrupt source block with Avalon-MM slave.
// Assumes a 25 MHz system clock, word addressing and async source inputs.
`include "tah_map.vh"
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Add 200 to nanosecond counter every 200 ns tick from 5 MHz timebase.
// - At one billion, zero nanoseconds and increment seconds together.
// - Both counters readable; separate reads may see mismatched halves.
// - Alarm decrements by 200 on each tick.
// - Alarm top bit set raises alarm interrupt source.
// - Hold bit set blocks comms processor memory bus access.
// - Hold timeout or repeated set raises error and frees bus.
// - Hold flag bit 0, hold error flag bit 1.
// - Error clears hold flag, sets sticky error until software clears.
// - Hold register state readable by software.
// - Six-bit nonzero exception code drives its processor source bit.
// - Exception codes use the documented encoding table.
// - Misaligned address reported as data access exception code.
// - External and internal interrupt are OR of masked sources.
// - Bit 0 reserved; bits 1-6 processor exceptions in order.
// - Bits 9-15 external device interrupts 1 to 7.
// - Bit 16 three queue processors halted; bit 17 inputters halted.
module tah_top #(
  parameter NEXT_DEV  = 7,
  parameter HOLD_TICKS = `TAH_HOLD_TICKS
) (
  // Clock and reset
  input  wire        i_sys_clk,
  input  wire        i_nrst,
  // Avalon-MM slave
  input  wire [3:0]  i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  input  wire [3:0]  i_avs_byteenable,
  output wire [31:0] o_avs_readdata,
  output wire        o_avs_waitrequest,
  output wire [1:0]  o_avs_response,
  // Processor exception codes
  input  wire [5:0]  i_cmd_exc,
  input  wire [5:0]  i_inp0_exc,
  input  wire [5:0]  i_inp1_exc,
  input  wire [5:0]  i_reply_engine_exc,
  input  wire [5:0]  i_thread_exc,
  input  wire [5:0]  i_dma_exc,
  // Misaligned access indication into the exception path
  input  wire        i_misalign,
  output wire [5:0]  o_misalign_code,
  // Halt status and external devices
  input  wire        i_others_halted,
  input  wire        i_inputs_halted,
  input  wire [NEXT_DEV-1:0] i_ext_dev_irq,
  // Outputs
  output wire        o_bus_hold,
  output wire        o_irq_ext,
  output wire        o_irq_int
);
  // ----------------------------------------------------------------
  // Constants, registers and nets
  // ----------------------------------------------------------------
  // Divider assumes the system clock is a whole multiple of the reference
  localparam integer TICK_DIV  = `TAH_SYS_MHZ / `TAH_REF_MHZ;
  localparam [31:0]  TICK_FULL = TICK_DIV - 1;
  localparam [2:0]   TICK_LAST = TICK_FULL[2:0];
  localparam NPROC   = `TAH_SRC_PROC_HI - `TAH_SRC_PROC_LO + 1;
  localparam EXC_W   = 6;
  localparam ST_IDLE = 1'b0;
  localparam ST_ACK  = 1'b1;

  reg        st_r;
  reg [31:0] rdata_r;
  reg [1:0]  resp_r;
  reg [2:0]  div_r;
  reg        tick_r;
  reg [31:0] ns_r;
  reg [31:0] sec_r;
  reg [31:0] alarm_r;
  reg        hold_r;
  reg        hold_err_r;
  reg [11:0] hold_cnt_r;
  reg [31:0] mask_ext_r;
  reg [31:0] mask_int_r;
  reg [31:0] src_r;
  reg [31:0] src_nxt;
  reg [31:0] rd_nxt;
  reg        mapped;
  reg        hold_fault;
  wire [31:0]         wmask;
  wire [NEXT_DEV-1:0] ext_sync;
  wire [1:0]          halt_sync;
  wire                wr_acc;
  wire                hold_wr;
  wire                hold_set_wr;
  wire                wr_alarm;
  wire                wr_mask_ext;
  wire                wr_mask_int;
  wire [NPROC*EXC_W-1:0] exc_all;
  wire [NPROC-1:0]    proc_flag;
  genvar              g;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  tah_sync #(
    .WIDTH (NEXT_DEV)
  ) u_ext_sync (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .i_async   (i_ext_dev_irq),
    .o_sync    (ext_sync)
  );

  // Halt flags come from other clock domains
  tah_sync #(
    .WIDTH (2)
  ) u_halt_sync (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .i_async   ({i_inputs_halted, i_others_halted}),
    .o_sync    (halt_sync)
  );

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  // One wait state: request taken in idle, answered next cycle
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & (st_r == ST_IDLE);
  assign o_avs_readdata    = rdata_r;
  assign o_avs_response    = resp_r;
  // Writes land at the edge that ends the answer cycle, one edge after the wait state ends
  assign wr_acc            = i_avs_write & (st_r == ST_ACK);
  assign wr_alarm          = wr_acc & (i_avs_address == `TAH_OFF_ALARM);
  assign wr_mask_ext       = wr_acc & (i_avs_address == `TAH_OFF_MASK_EXT);
  assign wr_mask_int       = wr_acc & (i_avs_address == `TAH_OFF_MASK_INT);
  assign hold_wr = wr_acc & (i_avs_address == `TAH_OFF_HOLD) & i_avs_byteenable[0];
  assign hold_set_wr = hold_wr & i_avs_writedata[`TAH_HOLD_BIT];

  // Byte lanes; the hold register looks at lane 0 only
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_lane
      assign wmask[8*g +: 8] = {8{i_avs_byteenable[g]}};
    end
  endgenerate

  always @*
  begin
    mapped = 1'b1;
    case (i_avs_address)
      `TAH_OFF_NS:       rd_nxt = ns_r;
      `TAH_OFF_SEC:      rd_nxt = sec_r;
      `TAH_OFF_ALARM:    rd_nxt = alarm_r;
      `TAH_OFF_HOLD:     rd_nxt = {30'h0000_0000, hold_err_r, hold_r};
      `TAH_OFF_SRC:      rd_nxt = src_r;
      `TAH_OFF_MASK_EXT: rd_nxt = mask_ext_r;
      `TAH_OFF_MASK_INT: rd_nxt = mask_int_r;
      default:
      begin
        rd_nxt = `TAH_ZERO32;
        mapped = 1'b0;
      end
    endcase
  end

  always @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      st_r    <= ST_IDLE;
      rdata_r <= `TAH_ZERO32;
      resp_r  <= 2'h0;
    end
    else
    begin
      case (st_r)
        ST_IDLE:
        begin
          if (i_avs_read | i_avs_write)
          begin
            st_r    <= ST_ACK;
            // Unmapped index answers with an error and zero data
            rdata_r <= i_avs_read ? rd_nxt : `TAH_ZERO32;
            resp_r  <= mapped ? 2'h0 : 2'h2;
          end
        end
        ST_ACK:
          st_r <= ST_IDLE;
        default:
          st_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Timebase and clock
  // ----------------------------------------------------------------
  // Tick is a one-cycle strobe, never a derived clock
  always @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      div_r  <= 3'h0;
      tick_r <= 1'b0;
    end
    else
    begin
      tick_r <= (div_r == TICK_LAST);
      div_r  <= (div_r == TICK_LAST) ? 3'h0 : div_r + 3'h1;
    end
  end

  always @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ns_r  <= `TAH_ZERO32;
      sec_r <= `TAH_ZERO32;
    end
    else if (tick_r)
    begin
      if (ns_r + `TAH_TICK_NS >= `TAH_NS_WRAP)
      begin
        ns_r  <= `TAH_ZERO32;
        sec_r <= sec_r + 32'h0000_0001;
      end
      else
        ns_r <= ns_r + `TAH_TICK_NS;
    end
  end

  // ----------------------------------------------------------------
  // Alarm
  // ----------------------------------------------------------------
  // A software write beats a tick in the same cycle
  always @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      alarm_r <= `TAH_ZERO32;
    else if (wr_alarm)
      alarm_r <= (alarm_r & ~wmask) | (i_avs_writedata & wmask);
    else if (tick_r)
      alarm_r <= alarm_r - `TAH_TICK_NS;
  end

  // ----------------------------------------------------------------
  // Bus hold
  // ----------------------------------------------------------------
  always @*
  begin
    hold_fault = 1'b0;
    if (hold_r && hold_set_wr)
      hold_fault = 1'b1;
    if (hold_r && tick_r && hold_cnt_r == HOLD_TICKS - 12'h001)
      hold_fault = 1'b1;
  end

  // Counter runs only while held; every hold write rewinds it
  always @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      hold_r     <= 1'b0;
      hold_err_r <= 1'b0;
      hold_cnt_r <= 12'h000;
    end
    else
    begin
      if (hold_fault)
      begin
        hold_r     <= 1'b0;
        hold_cnt_r <= 12'h000;
      end
      else if (hold_wr)
      begin
        hold_r     <= i_avs_writedata[`TAH_HOLD_BIT];
        hold_cnt_r <= 12'h000;
      end
      else if (hold_r && tick_r)
        hold_cnt_r <= hold_cnt_r + 12'h001;
      // Set wins over a clear in the same cycle
      if (hold_fault)
        hold_err_r <= 1'b1;
      else if (hold_wr && !i_avs_writedata[`TAH_HOLD_ERR_BIT])
        hold_err_r <= 1'b0;
    end
  end

  assign o_bus_hold = hold_r;

  // ----------------------------------------------------------------
  // Interrupt sources and masks
  // ----------------------------------------------------------------
  assign o_misalign_code = i_misalign ? `TAH_EXC_DATA_ACC : `TAH_EXC_NONE;

  // ----------------------------------------------------------------
  // Processor exception flags
  // ----------------------------------------------------------------
  // Concatenation order sets the bit order: command lowest, DMA highest
  assign exc_all = {i_dma_exc, i_thread_exc, i_reply_engine_exc,
                    i_inp1_exc, i_inp0_exc, i_cmd_exc};
  generate
    for (g = 0; g < NPROC; g = g + 1)
    begin : g_proc
      assign proc_flag[g] = (exc_all[EXC_W*g +: EXC_W] != `TAH_EXC_NONE);
    end
  endgenerate

  // Bit 0 stays zero as reserved
  always @*
  begin
    src_nxt = `TAH_ZERO32;
    src_nxt[`TAH_SRC_PROC_HI:`TAH_SRC_PROC_LO] = proc_flag;
    src_nxt[`TAH_SRC_ALARM] = alarm_r[31];
    src_nxt[`TAH_SRC_HOLD_ERR] = hold_err_r;
    src_nxt[`TAH_SRC_EXT_HI:`TAH_SRC_EXT_LO] = ext_sync;
    src_nxt[`TAH_SRC_OTH_HALT] = halt_sync[0];
    src_nxt[`TAH_SRC_INP_HALT] = halt_sync[1];
  end

  always @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      src_r      <= `TAH_ZERO32;
      mask_ext_r <= `TAH_ZERO32;
      mask_int_r <= `TAH_ZERO32;
    end
    else
    begin
      // Registered so both interrupt lines see one snapshot
      src_r <= src_nxt;
      if (wr_mask_ext)
        mask_ext_r <= (mask_ext_r & ~wmask) | (i_avs_writedata & wmask);
      if (wr_mask_int)
        mask_int_r <= (mask_int_r & ~wmask) | (i_avs_writedata & wmask);
    end
  end

  assign o_irq_ext = |(src_r & mask_ext_r);
  assign o_irq_int = |(src_r & mask_int_r);
endmodule // tah_top
`default_nettype wire

//--- tah_top_monitor.sv
// Concurrent checks on the bus, hold and misalign pins of tah_top.
// Assumes it is bound into tah_top and shares its HOLD_TICKS value.
`timescale 1ns/100ps
`default_nettype none
module tah_top_monitor #(
  parameter HOLD_TICKS = 12'h09c4
) (
  // Clock and reset
  input wire        i_sys_clk,
  input wire        i_nrst,
  // Bus
  input wire [3:0]  i_avs_address,
  input wire        i_avs_read,
  input wire        i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0]  i_avs_byteenable,
  input wire [31:0] o_avs_readdata,
  input wire        o_avs_waitrequest,
  input wire [1:0]  o_avs_response,
  // Misalign and hold
  input wire        i_misalign,
  input wire [5:0]  o_misalign_code,
  input wire        o_bus_hold
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_nrst);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  wire         req = i_avs_read || i_avs_write;
  // Write to the hold register in the cycle it lands
  wire         hw  = i_avs_write && !o_avs_waitrequest && i_avs_address == 4'h3
                     && i_avs_byteenable[0];
  logic [15:0] hold_cnt_r;
  // Counter, since the timeout is far beyond a repetition bound
  always @(posedge i_sys_clk or negedge i_nrst)
    if (!i_nrst)
      hold_cnt_r <= 16'h0000;
    else
      hold_cnt_r <= o_bus_hold ? hold_cnt_r + 16'h0001 : 16'h0000;
  sequence s_take;
    req && o_avs_waitrequest;
  endsequence
  sequence s_idle2;
    !req ##1 !req;
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_one_wait: assert property (s_take |=> !o_avs_waitrequest)
    else $error("no answer after one wait state");
  a_idle_nowait: assert property (!req |-> !o_avs_waitrequest)
    else $error("waitrequest without request");
  a_unmapped_err: assert property (s_take ##0 (i_avs_read && i_avs_address > 4'h6)
    |=> o_avs_response == 2'b10 && o_avs_readdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  a_mapped_ok: assert property (s_take ##0 (i_avs_address < 4'h7) |=> o_avs_response == 2'b00)
    else $error("mapped access refused");
  a_read_holds: assert property (s_idle2 |-> $stable(o_avs_readdata))
    else $error("read data moved while idle");
  a_misalign_map: assert property (o_misalign_code == (i_misalign ? 6'h04 : 6'h00))
    else $error("misalign code wrong");
  a_hold_set: assert property (!o_bus_hold && hw && i_avs_writedata[0] |-> ##[1:2] o_bus_hold)
    else $error("hold not set");
  a_hold_refault: assert property (o_bus_hold && hw && i_avs_writedata[0] |-> ##[1:2] !o_bus_hold)
    else $error("second set did not free bus");
  a_hold_clear: assert property (hw && !i_avs_writedata[0] |-> ##[1:2] !o_bus_hold)
    else $error("hold not cleared");
  a_hold_bound: assert property (hold_cnt_r <= HOLD_TICKS * 5 + 6)
    else $error("hold outlived its timeout");
endmodule // tah_top_monitor
bind tah_top tah_top_monitor #(.HOLD_TICKS(HOLD_TICKS)) mon_u (
  .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .o_avs_response(o_avs_response),
  .i_misalign(i_misalign), .o_misalign_code(o_misalign_code), .o_bus_hold(o_bus_hold)
);
`default_nettype wire

//--- tah_top_test.sv
// Self-checking bench for the timer, alarm, hold and source block.
// Assumes tah_top with a short hold timeout and the bound monitor.
`timescale 1ns/100ps
`default_nettype none
module tah_top_test;
  localparam int HT = 4;
  logic        sys_clk;
  logic        nrst = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0000_0000;
  logic [5:0]  exc [6] = '{default: 6'h00};
  logic [6:0]  dev = 7'h00;
  logic        mis = 1'b0;
  logic        oh = 1'b0;
  logic        ih = 1'b0;
  logic [31:0] rdata;
  logic [1:0]  rsp;
  logic [31:0] v;
  logic [5:0]  codes [11] = '{6'h00, 6'h04, 6'h08, 6'h09, 6'h0b, 6'h0c, 6'h0d,
                              6'h10, 6'h11, 6'h12, 6'h14};
  wire  [31:0] o_rd;
  wire  [1:0]  o_rsp;
  wire  [5:0]  o_mc;
  wire         o_wt, o_hold, o_ie, o_ii;
  int          n_fail, n_checks, seed, i, p;

  tah_top #(.HOLD_TICKS(HT)) dut_u (
    .i_sys_clk(sys_clk), .i_nrst(nrst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf),
    .o_avs_readdata(o_rd), .o_avs_waitrequest(o_wt), .o_avs_response(o_rsp),
    .i_cmd_exc(exc[0]), .i_inp0_exc(exc[1]), .i_inp1_exc(exc[2]),
    .i_reply_engine_exc(exc[3]), .i_thread_exc(exc[4]), .i_dma_exc(exc[5]),
    .i_misalign(mis), .o_misalign_code(o_mc), .i_others_halted(oh),
    .i_inputs_halted(ih), .i_ext_dev_irq(dev), .o_bus_hold(o_hold),
    .o_irq_ext(o_ie), .o_irq_int(o_ii)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // ----------------------------------------------------------------
  // Tasks and expectations
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Answer taken at the rising edge that sees waitrequest low
  task automatic bus(input logic w_n, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    rd <= !w_n;
    wr <= w_n;
    adr <= a;
    wd <= d;
    for (k = 0; k < 40; k++)
    begin
      @(posedge sys_clk);
      if (o_wt === 1'b0)
        break;
    end
    if (k == 40)
    begin
      $display("MISMATCH waitrequest expected 0 seen %b", o_wt);
      n_fail++;
      conclude();
    end
    rdata = o_rd;
    rsp = o_rsp;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk($sformatf("reg%0h", a), e, rdata & m);
  endtask
  function automatic logic [16:0] f_src();
    logic [5:0] pv;
    for (int j = 0; j < 6; j++)
      pv[j] = exc[j] != 6'h00;
    return {ih, oh, dev, 2'b00, pv};
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    seed = 32'h0000_8d77;
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    rdc(4'h3, '1, 0);
    rdc(4'h5, '1, 0);
    rdc(4'h6, '1, 0);
    rdc(4'hb, '1, 0);
    chk("resp", 2, rsp);
    $display("test reset done");
    bus(1'b0, 4'h0, 0);
    v = rdata;
    repeat (50) @(posedge sys_clk);
    bus(1'b0, 4'h0, 0);
    v = rdata - v;
    chk("ns_step", 1, v == 2000 || v == 2200);
    rdc(4'h1, '1, 0);
    $display("test timer done");
    v = $random(seed);
    v[31:30] = 2'b01;
    bus(1'b1, 4'h2, v);
    bus(1'b0, 4'h2, 0);
    v = v - rdata;
    chk("alarm_dec", 1, v % 200 == 0 && v <= 600);
    bus(1'b1, 4'h2, 32'h0000_0258);
    repeat (30) @(posedge sys_clk);
    rdc(4'h4, 32'h0000_0080, 32'h0000_0080);
    bus(1'b1, 4'h5, 32'h0000_0080);
    repeat (3) @(posedge sys_clk);
    chk("irq_ext", 1, o_ie);
    chk("irq_int", 0, o_ii);
    bus(1'b1, 4'h6, 32'h0000_0080);
    repeat (3) @(posedge sys_clk);
    chk("irq_int", 1, o_ii);
    bus(1'b1, 4'h2, 32'h7fff_0000);
    repeat (3) @(posedge sys_clk);
    chk("irq_lvl", 0, o_ii);
    $display("test alarm done");
    for (i = 0; i < 22; i++)
    begin
      p = $unsigned($random(seed)) % 6;
      exc[p] <= codes[i % 11];
      oh <= $random(seed);
      ih <= $random(seed);
      dev <= $random(seed);
      repeat (8) @(posedge sys_clk);
      rdc(4'h4, 32'h0003_fe7f, {f_src(), 1'b0});
    end
    mis <= 1'b1;
    @(posedge sys_clk);
    chk("mis_code", 32'h0000_0004, o_mc);
    mis <= 1'b0;
    $display("test sources done");
    bus(1'b1, 4'h3, 1);
    @(posedge sys_clk);
    chk("hold_on", 1, o_hold);
    rdc(4'h3, '1, 1);
    bus(1'b1, 4'h3, 1);
    @(posedge sys_clk);
    chk("hold_refault", 0, o_hold);
    rdc(4'h3, '1, 2);
    rdc(4'h4, 32'h0000_0100, 32'h0000_0100);
    bus(1'b1, 4'h3, 0);
    rdc(4'h3, '1, 0);
    bus(1'b1, 4'h3, 1);
    repeat (HT * 5 - 8) @(posedge sys_clk);
    chk("hold_wait", 1, o_hold);
    repeat (16) @(posedge sys_clk);
    chk("hold_tmo", 0, o_hold);
    rdc(4'h3, '1, 2);
    $display("test hold done");
    conclude();
  end
  // Whole run is a few hundred cycles
  initial
  begin
    repeat (8000) @(posedge sys_clk);
    n_fail++;
    conclude();
  end
endmodule // tah_top_test
`default_nettype wire
